// ===== pkg/dqtf_pkg.sv
// Purpose: shared types and constants of the dq training pattern/fifo block
// Assumes: lanes, burst and fifo depth as used by the training commands
// Notes: mode register addresses and bit positions live here only
package dqtf_pkg;
	localparam int LANES = 16;
	localparam int DMIS = 2;
	localparam int BURST = 16;
	localparam int DEPTH = 5;
	localparam int PTR_W = 3;
	localparam int BEAT_W = 4;

	// mode register addresses reached by the register write command
	localparam logic [5:0] MA_DBI = 6'h03;
	localparam logic [5:0] MA_DM = 6'h0D;
	localparam logic [5:0] MA_INV_LO = 6'h0F;
	localparam logic [5:0] MA_INV_HI = 6'h14;
	localparam logic [5:0] MA_PAT_LO = 6'h20;
	localparam logic [5:0] MA_PAT_HI = 6'h28;

	// field positions
	localparam int BIT_WR_DBI = 7;
	localparam int BIT_RD_DBI = 6;
	localparam int BIT_DM_DIS = 5;
	localparam int BIT_MPC_EN = 6;

	// reset values
	localparam logic [7:0] RST_PAT_LO = 8'h5A;
	localparam logic [7:0] RST_PAT_HI = 8'h3C;
	localparam logic [7:0] RST_INV = 8'h55;
	localparam logic [7:0] RST_DBI = 8'h00;
	localparam logic [7:0] RST_DM = 8'h00;

	// training function codes in operand bits 5..0
	localparam logic [5:0] MPC_RD_FIFO = 6'h01;
	localparam logic [5:0] MPC_RD_CAL = 6'h03;
	localparam logic [5:0] MPC_WR_FIFO = 6'h07;

	typedef enum logic [1:0] {K_NONE, K_RD_CAL, K_RD_FIFO, K_WR_FIFO}
		dqtf_kind_t;

	// one data beat across all lanes
	typedef struct packed {
		logic [DMIS-1:0] dmi;
		logic [LANES-1:0] dq;
	} dqtf_beat_t;

	// burst waiting for its latency to expire
	typedef struct packed {
		logic valid;
		dqtf_kind_t kind;
		logic [PTR_W-1:0] idx;
	} dqtf_slot_t;

	// decoded command pins, each flag marks the command's last rising edge
	typedef struct packed {
		logic mpc;
		logic cas2;
		logic rd_array;
		logic wr_array;
		logic mrr;
		logic mrw;
		logic pd_entry;
		logic sref_pd_entry;
		logic [7:0] op;
		logic [5:0] ma;
	} dqtf_cmd_t;
endpackage

// ===== verilog/dqtf_core.sv
// Purpose: read dq calibration pattern source and five-entry write/read fifo
// Assumes: ck, commands and data arrive unsynchronised and are sampled here
// Notes: ck is oversampled; every ck edge is one data beat
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - calibration data uses read latency and strobe timing of a plain read.
// - back-to-back calibration bursts run seamlessly with no gap.
// - bursts are 16 beats, toggling preamble, half-cycle postamble.
// - first pattern byte then second byte on every dq and dmi lane.
// - each pattern byte leaves bit 0 first.
// - invert masks touch dq lanes only, never dmi.
// - no bus inversion is applied during calibration.
// - dmi floats only when mask off and both inversion modes off.
// - multi-purpose command with operand bit 6 low is a no-operation.
// - operand bit 6 high decodes bits 5..0; unknown codes are ignored.
// - write fifo capture uses write latency from cas-2 second edge.
// - read fifo data uses read latency from cas-2 second edge.
// - fifo holds five bursts of sixteen beats per pin.
// - fifo reads never change contents; only fifo writes overwrite.
// - unwritten entries read back as defined levels.
// - successive fifo reads step entries first to fifth, then wrap.
// - invert mask bit one inverts that dq lane; low byte, high byte.
// - reset loads patterns 5A, 3C and both masks 55.
// - pointers clear on reset, power-down and self-refresh power-down.
// - fifo write/read advance their pointer; array read advances both.
module dqtf_core #(
	parameter int LAT_W = 5
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// link pins
	input wire logic ck,
	input wire dqtf_pkg::dqtf_cmd_t cmd_i,
	input wire dqtf_pkg::dqtf_beat_t bus_i,
	output var dqtf_pkg::dqtf_beat_t bus_o,
	output logic dq_oe_n,
	output logic dmi_oe_n,
	output logic dqs_o,
	output logic dqs_oe_n,
	// latency configuration
	input wire logic [LAT_W-1:0] read_latency,
	input wire logic [LAT_W-1:0] write_latency,
	// status
	output logic [dqtf_pkg::PTR_W-1:0] wr_fifo_ptr,
	output logic [dqtf_pkg::PTR_W-1:0] rd_fifo_ptr
);
	localparam int QDEPTH = 2 ** LAT_W;
	localparam int CMD_W = $bits(dqtf_pkg::dqtf_cmd_t);
	localparam int DAT_W = $bits(dqtf_pkg::dqtf_beat_t);
	localparam int SYNC_W = 1 + CMD_W + DAT_W;
	localparam logic [dqtf_pkg::BEAT_W-1:0] LAST_BEAT =
		dqtf_pkg::BEAT_W'(dqtf_pkg::BURST - 1);

	typedef enum logic [1:0] {TX_IDLE, TX_PRE, TX_DATA, TX_POST} dqtf_tx_t;

	// modulo-five pointer step, shared by both pointers
	function automatic logic [dqtf_pkg::PTR_W-1:0] ptr_inc(
		input logic [dqtf_pkg::PTR_W-1:0] p);
		ptr_inc = (p == dqtf_pkg::PTR_W'(dqtf_pkg::DEPTH - 1)) ? '0 :
			dqtf_pkg::PTR_W'(p + 1'b1);
	endfunction

	// training function decode of the multi-purpose operand
	function automatic dqtf_pkg::dqtf_kind_t mpc_kind(input logic [7:0] op);
		mpc_kind = dqtf_pkg::K_NONE;
		if (op[dqtf_pkg::BIT_MPC_EN]) begin
			case (op[5:0])
			dqtf_pkg::MPC_RD_FIFO: mpc_kind = dqtf_pkg::K_RD_FIFO;
			dqtf_pkg::MPC_RD_CAL: mpc_kind = dqtf_pkg::K_RD_CAL;
			dqtf_pkg::MPC_WR_FIFO: mpc_kind = dqtf_pkg::K_WR_FIFO;
			default: mpc_kind = dqtf_pkg::K_NONE;
			endcase
		end
	endfunction

	// two-flop synchronisers for every pin; only stage two is read
	logic [SYNC_W-1:0] sync1_reg;
	logic [SYNC_W-1:0] sync2_reg;
	logic ck_prev_reg;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			ck_prev_reg <= 1'b0;
		end else begin
			sync1_reg <= {ck, cmd_i, bus_i};
			sync2_reg <= sync1_reg;
			ck_prev_reg <= sync2_reg[SYNC_W-1];
		end
	end

	// edge detection and command decode
	wire logic ck_s;
	dqtf_pkg::dqtf_cmd_t cmd_s;
	dqtf_pkg::dqtf_beat_t din_s;
	assign {ck_s, cmd_s, din_s} = sync2_reg;
	wire logic ck_rise = ck_s & ~ck_prev_reg;
	wire logic ck_fall = ~ck_s & ck_prev_reg;
	wire logic ck_edge = ck_rise | ck_fall;

	dqtf_pkg::dqtf_kind_t pend_reg;
	wire logic is_mpc = ck_rise & cmd_s.mpc;
	wire logic other_cmd = ck_rise & (cmd_s.cas2 | cmd_s.rd_array |
		cmd_s.wr_array | cmd_s.mrr | cmd_s.mrw | cmd_s.pd_entry |
		cmd_s.sref_pd_entry);
	wire logic cas2_go = ck_rise & cmd_s.cas2 &
		(pend_reg != dqtf_pkg::K_NONE);
	wire logic go_wr = cas2_go & (pend_reg == dqtf_pkg::K_WR_FIFO);
	wire logic go_rdf = cas2_go & (pend_reg == dqtf_pkg::K_RD_FIFO);
	wire logic arr_rd = ck_rise & cmd_s.rd_array;
	wire logic ptr_clr = ck_rise & (cmd_s.pd_entry | cmd_s.sref_pd_entry);
	// a stray command between mpc and cas-2 drops the pending training
	wire dqtf_pkg::dqtf_kind_t pend_next = is_mpc ? mpc_kind(cmd_s.op) :
		(other_cmd ? dqtf_pkg::K_NONE : pend_reg);

	// fifo pointers
	logic [dqtf_pkg::PTR_W-1:0] wr_ptr_reg;
	logic [dqtf_pkg::PTR_W-1:0] rd_ptr_reg;
	wire logic [dqtf_pkg::PTR_W-1:0] wr_ptr_next = ptr_clr ? '0 :
		((go_wr | arr_rd) ? ptr_inc(wr_ptr_reg) : wr_ptr_reg);
	wire logic [dqtf_pkg::PTR_W-1:0] rd_ptr_next = ptr_clr ? '0 :
		((go_rdf | arr_rd) ? ptr_inc(rd_ptr_reg) : rd_ptr_reg);
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pend_reg <= dqtf_pkg::K_NONE;
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end else begin
			pend_reg <= pend_next;
			wr_ptr_reg <= wr_ptr_next;
			rd_ptr_reg <= rd_ptr_next;
		end
	end
	assign wr_fifo_ptr = wr_ptr_reg;
	assign rd_fifo_ptr = rd_ptr_reg;

	// mode registers that shape the pattern and dmi drive
	logic [7:0] pat_lo_reg;
	logic [7:0] pat_hi_reg;
	logic [7:0] inv_lo_reg;
	logic [7:0] inv_hi_reg;
	logic [7:0] dbi_reg;
	logic [7:0] dm_reg;
	wire logic mrw_go = ck_rise & cmd_s.mrw;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pat_lo_reg <= dqtf_pkg::RST_PAT_LO;
			pat_hi_reg <= dqtf_pkg::RST_PAT_HI;
			inv_lo_reg <= dqtf_pkg::RST_INV;
			inv_hi_reg <= dqtf_pkg::RST_INV;
			dbi_reg <= dqtf_pkg::RST_DBI;
			dm_reg <= dqtf_pkg::RST_DM;
		end else if (mrw_go) begin
			case (cmd_s.ma)
			dqtf_pkg::MA_PAT_LO: pat_lo_reg <= cmd_s.op;
			dqtf_pkg::MA_PAT_HI: pat_hi_reg <= cmd_s.op;
			dqtf_pkg::MA_INV_LO: inv_lo_reg <= cmd_s.op;
			dqtf_pkg::MA_INV_HI: inv_hi_reg <= cmd_s.op;
			dqtf_pkg::MA_DBI: dbi_reg <= cmd_s.op;
			dqtf_pkg::MA_DM: dm_reg <= cmd_s.op;
			default: ;
			endcase
		end
	end

	// latency line: a slot inserted at latency-1 is taken latency rises later
	dqtf_pkg::dqtf_slot_t lat_q [QDEPTH];
	wire logic [LAT_W-1:0] lat_sel = go_wr ? write_latency : read_latency;
	wire logic [LAT_W-1:0] ins_pos = (lat_sel == '0) ? '0 :
		LAT_W'(lat_sel - 1'b1);
	wire dqtf_pkg::dqtf_slot_t new_slot = '{valid: 1'b1, kind: pend_reg,
		idx: go_wr ? wr_ptr_reg : rd_ptr_reg};
	genvar g;
	generate
		for (g = 0; g < QDEPTH; g++) begin : g_lat
			dqtf_pkg::dqtf_slot_t upper;
			if (g == QDEPTH - 1) begin : g_top
				assign upper = '0;
			end else begin : g_mid
				assign upper = lat_q[g+1];
			end
			always_ff @(posedge sys_clk) begin
				if (rst)
					lat_q[g] <= '0;
				else if (ck_rise)
					lat_q[g] <= (cas2_go && ins_pos == LAT_W'(g)) ?
						new_slot : upper;
			end
		end
	endgenerate

	wire dqtf_pkg::dqtf_slot_t head = lat_q[0];
	wire dqtf_pkg::dqtf_slot_t soon = lat_q[1];
	wire logic head_tx = ck_rise & head.valid &
		(head.kind != dqtf_pkg::K_WR_FIFO);
	wire logic head_rx = ck_rise & head.valid &
		(head.kind == dqtf_pkg::K_WR_FIFO);

	// training fifo storage, flops indexed by entry and beat
	dqtf_pkg::dqtf_beat_t fifo_mem [dqtf_pkg::DEPTH][dqtf_pkg::BURST];
	logic rx_active_reg;
	logic [dqtf_pkg::PTR_W-1:0] rx_idx_reg;
	logic [dqtf_pkg::BEAT_W-1:0] rx_cnt_reg;
	wire logic rx_step = rx_active_reg & ck_edge & (rx_cnt_reg != LAST_BEAT);
	wire logic mem_we = head_rx | rx_step;
	wire logic [dqtf_pkg::PTR_W-1:0] w_idx = head_rx ? head.idx : rx_idx_reg;
	wire logic [dqtf_pkg::BEAT_W-1:0] w_cnt = head_rx ? '0 :
		dqtf_pkg::BEAT_W'(rx_cnt_reg + 1'b1);
	// cleared storage gives defined levels for never-written entries
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			for (int e = 0; e < dqtf_pkg::DEPTH; e++)
				for (int b = 0; b < dqtf_pkg::BURST; b++)
					fifo_mem[e][b] <= '0;
		end else if (mem_we) begin
			fifo_mem[w_idx][w_cnt] <= din_s;
		end
	end

	// write capture sequencing; a new head wins so bursts chain seamlessly
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rx_active_reg <= 1'b0;
			rx_idx_reg <= '0;
			rx_cnt_reg <= '0;
		end else if (head_rx) begin
			rx_active_reg <= 1'b1;
			rx_idx_reg <= head.idx;
			rx_cnt_reg <= '0;
		end else if (rx_active_reg && ck_edge) begin
			rx_active_reg <= rx_step;
			rx_cnt_reg <= w_cnt;
		end
	end

	// transmit beat selection, reads leave storage untouched
	dqtf_tx_t tx_state_reg;
	dqtf_pkg::dqtf_slot_t tx_slot_reg;
	logic [dqtf_pkg::BEAT_W-1:0] tx_cnt_reg;
	wire dqtf_pkg::dqtf_slot_t t_slot = head_tx ? head : tx_slot_reg;
	wire logic [dqtf_pkg::BEAT_W-1:0] t_cnt = head_tx ? '0 :
		dqtf_pkg::BEAT_W'(tx_cnt_reg + 1'b1);
	wire logic [7:0] t_byte = t_cnt[3] ? pat_hi_reg : pat_lo_reg;
	wire logic cal_bit = t_byte[t_cnt[2:0]];
	wire dqtf_pkg::dqtf_beat_t cal_beat = '{dmi: {dqtf_pkg::DMIS{cal_bit}},
		dq: {dqtf_pkg::LANES{cal_bit}} ^ {inv_hi_reg, inv_lo_reg}};
	// fifo read path for the slot index; idx never exceeds the last entry
	wire dqtf_pkg::dqtf_beat_t fifo_beat = fifo_mem[t_slot.idx][t_cnt];
	// data goes out as stored; no inversion coding in any training burst
	wire dqtf_pkg::dqtf_beat_t t_beat =
		(t_slot.kind == dqtf_pkg::K_RD_CAL) ? cal_beat : fifo_beat;
	wire logic dmi_drive = ~dm_reg[dqtf_pkg::BIT_DM_DIS] |
		dbi_reg[dqtf_pkg::BIT_WR_DBI] | dbi_reg[dqtf_pkg::BIT_RD_DBI];
	wire logic tx_last = (tx_state_reg == TX_DATA) && ck_edge &&
		(tx_cnt_reg == LAST_BEAT);
	wire logic pre_go = ck_rise & soon.valid &
		(soon.kind != dqtf_pkg::K_WR_FIFO) & (tx_state_reg != TX_DATA);

	// transmit state; strobe follows ck, one ck preamble, half ck postamble
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			tx_state_reg <= TX_IDLE;
			tx_slot_reg <= '0;
			tx_cnt_reg <= '0;
			bus_o <= '0;
			dq_oe_n <= 1'b1;
			dmi_oe_n <= 1'b1;
			dqs_o <= 1'b0;
			dqs_oe_n <= 1'b1;
		end else if (head_tx || (tx_state_reg == TX_DATA && ck_edge &&
			!tx_last)) begin
			tx_state_reg <= TX_DATA;
			tx_slot_reg <= t_slot;
			tx_cnt_reg <= t_cnt;
			bus_o <= t_beat;
			dq_oe_n <= 1'b0;
			dmi_oe_n <= ~dmi_drive;
			dqs_o <= ck_rise;
			dqs_oe_n <= 1'b0;
		end else if (pre_go) begin
			tx_state_reg <= TX_PRE;
			dq_oe_n <= 1'b1;
			dmi_oe_n <= 1'b1;
			dqs_o <= 1'b1;
			dqs_oe_n <= 1'b0;
		end else if (ck_edge) begin
			case (tx_state_reg)
			TX_PRE: dqs_o <= ck_rise;
			TX_DATA: begin
				tx_state_reg <= TX_POST;
				dq_oe_n <= 1'b1;
				dmi_oe_n <= 1'b1;
				dqs_o <= 1'b0;
			end
			TX_POST: begin
				tx_state_reg <= TX_IDLE;
				dqs_oe_n <= 1'b1;
			end
			default: tx_state_reg <= TX_IDLE;
			endcase
		end
	end
endmodule // dqtf_core

`default_nettype wire

// ===== testbench/dqtf_core_assertions.sv
// Purpose: port-level checks of the dq training block
// Assumes: one sys_clk domain, ck pin oversampled by the block
// Notes: burst length is counted in raw ck pin edges
`timescale 1ns/1ns
`default_nettype none
module dqtf_core_assertions #(
	parameter int LAT_W = 5
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// link pins
	input wire logic ck,
	input wire dqtf_pkg::dqtf_cmd_t cmd_i,
	input wire dqtf_pkg::dqtf_beat_t bus_i,
	input wire dqtf_pkg::dqtf_beat_t bus_o,
	input wire logic dq_oe_n,
	input wire logic dmi_oe_n,
	input wire logic dqs_o,
	input wire logic dqs_oe_n,
	// configuration and status
	input wire logic [LAT_W-1:0] read_latency,
	input wire logic [LAT_W-1:0] write_latency,
	input wire logic [dqtf_pkg::PTR_W-1:0] wr_fifo_ptr,
	input wire logic [dqtf_pkg::PTR_W-1:0] rd_fifo_ptr
);
	logic ck_q;
	logic [6:0] edges;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	// pin edges while dq is driven; a slow sync would show up as 17
	always_ff @(posedge sys_clk) begin
		ck_q <= ck;
		edges <= (rst || dq_oe_n) ? 7'h00 : edges + 7'(ck != ck_q);
	end

	chk_dmi_in_burst:
		assert property (!dmi_oe_n |-> !dq_oe_n)
		else $error("dmi driven outside a burst");
	chk_burst_edges:
		assert property ($rose(dq_oe_n) |->
			edges[3:0] == 4'h0 && edges != 7'h00)
		else $error("burst is not a multiple of 16 beats");
	chk_post_low:
		assert property ($rose(dq_oe_n) |-> !dqs_oe_n && !dqs_o)
		else $error("no low postamble on strobe");
	chk_post_end:
		assert property ($rose(dq_oe_n) |-> ##[1:6] dqs_oe_n)
		else $error("strobe not released after half ck");
	chk_strobe_half:
		assert property (!dqs_oe_n && $changed(dqs_o) |=> $stable(dqs_o)[*3])
		else $error("strobe toggles faster than ck");
	chk_wr_step:
		assert property ($changed(wr_fifo_ptr) |-> wr_fifo_ptr <= 3'h4 &&
			(wr_fifo_ptr == 3'h0 || wr_fifo_ptr == $past(wr_fifo_ptr) + 3'h1))
		else $error("write pointer skipped");
	chk_rd_step:
		assert property ($changed(rd_fifo_ptr) |-> rd_fifo_ptr <= 3'h4 &&
			(rd_fifo_ptr == 3'h0 || rd_fifo_ptr == $past(rd_fifo_ptr) + 3'h1))
		else $error("read pointer skipped");
	chk_pd_clear:
		assert property ($rose(cmd_i.pd_entry || cmd_i.sref_pd_entry) |->
			##[1:12] (wr_fifo_ptr == 3'h0 && rd_fifo_ptr == 3'h0))
		else $error("pointers not cleared on power-down");
	chk_reset_quiet:
		assert property (disable iff (1'b0) rst |=> dq_oe_n && dmi_oe_n &&
			dqs_oe_n && wr_fifo_ptr == 3'h0 && rd_fifo_ptr == 3'h0)
		else $error("outputs not quiet after reset");
endmodule // dqtf_core_assertions

bind dqtf_core dqtf_core_assertions #(.LAT_W(LAT_W)) chk_u (
	.sys_clk(sys_clk), .rst(rst), .ck(ck), .cmd_i(cmd_i), .bus_i(bus_i),
	.bus_o(bus_o), .dq_oe_n(dq_oe_n), .dmi_oe_n(dmi_oe_n), .dqs_o(dqs_o),
	.dqs_oe_n(dqs_oe_n), .read_latency(read_latency),
	.write_latency(write_latency), .wr_fifo_ptr(wr_fifo_ptr),
	.rd_fifo_ptr(rd_fifo_ptr));
`default_nettype wire

// ===== testbench/dqtf_ctrl_model.sv
// Purpose: controller model driving ck, commands and write data
// Assumes: ck runs free at 80 ns, one command per ck period
// Notes: read beats are captured mid-beat into q for the bench
`timescale 1ns/1ns
`default_nettype none
module dqtf_ctrl_model #(
	parameter int RL = 2,
	parameter int WL = 2
) (
	// link pins toward the device
	output logic ck,
	output var dqtf_pkg::dqtf_cmd_t cmd,
	output var dqtf_pkg::dqtf_beat_t wbus,
	// device answers
	input wire dqtf_pkg::dqtf_beat_t rbus,
	input wire logic dq_oe_n,
	input wire logic dmi_oe_n
);
	logic [19:0] q [32];

	// commands change on ck fall, so they are settled around each rise
	initial begin
		ck = 1'b0;
		cmd = '0;
		wbus = '0;
	end
	always #40 ck = ~ck;

	// kind picks one flag bit from mpc downwards; 8 means idle
	task automatic send(input int kind, input logic [7:0] op,
		input logic [5:0] ma);
		@(negedge ck);
		cmd <= dqtf_pkg::dqtf_cmd_t'({8'h80 >> kind, op, ma});
	endtask

	function automatic dqtf_pkg::dqtf_beat_t wval(input int k, input int n);
		return dqtf_pkg::dqtf_beat_t'({2'(k + n), 4'(k), 4'(n),
			8'(k * 37 + n)});
	endfunction

	// training read bursts spaced eight ck apart
	task automatic rd(input logic [7:0] op, input int nb);
		fork
			for (int k = 0; k < nb; k++) begin
				send(0, op, 6'h00);
				send(1, 8'h00, 6'h00);
				repeat (6) send(8, 8'h00, 6'h00);
			end
			begin
				@(negedge ck);
				#(170 + 80 * RL);
				for (int i = 0; i < 16 * nb; i++) begin
					q[i] = {dq_oe_n, dmi_oe_n,
						dmi_oe_n ? 2'b00 : rbus.dmi, rbus.dq};
					#40;
				end
			end
		join
	endtask

	// fifo write: beat n straddles the n-th edge from write latency on
	task automatic wr(input int k);
		fork
			begin
				send(0, {2'b01, dqtf_pkg::MPC_WR_FIFO}, 6'h00);
				send(1, 8'h00, 6'h00);
				repeat (6) send(8, 8'h00, 6'h00);
			end
			begin
				@(negedge ck);
				#(110 + 80 * WL);
				for (int n = 0; n < 16; n++) begin
					wbus <= wval(k, n);
					#40;
				end
				wbus <= ~wbus; // released bus must not keep the last beat
			end
		join
	endtask
endmodule // dqtf_ctrl_model
`default_nettype wire

// ===== testbench/dqtf_core_bench.sv
// Purpose: self-checking bench of the dq training block
// Assumes: read latency 2, write latency 3, ck 80 ns
// Notes: each scenario drives and judges before it returns
`timescale 1ns/1ns
`default_nettype none
module dqtf_core_bench;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic ck;
	dqtf_pkg::dqtf_cmd_t cmd;
	dqtf_pkg::dqtf_beat_t wbus;
	dqtf_pkg::dqtf_beat_t rbus;
	logic dq_oe_n;
	logic dmi_oe_n;
	logic [2:0] wp;
	logic [2:0] rp;
	int n_fail = 0;
	int num_checks = 0;
	int cyc = 0;

	// latencies differ so a swapped latency select would show up
	dqtf_core #(.LAT_W(5)) dut_u (.sys_clk(sys_clk), .rst(rst), .ck(ck),
		.cmd_i(cmd), .bus_i(wbus), .bus_o(rbus), .dq_oe_n(dq_oe_n),
		.dmi_oe_n(dmi_oe_n), .dqs_o(), .dqs_oe_n(), .read_latency(5'h02),
		.write_latency(5'h03), .wr_fifo_ptr(wp), .rd_fifo_ptr(rp));
	dqtf_ctrl_model #(.RL(2), .WL(3)) model_u (.ck(ck), .cmd(cmd),
		.wbus(wbus), .rbus(rbus), .dq_oe_n(dq_oe_n), .dmi_oe_n(dmi_oe_n));

	// clock and a hang guard sized well above the whole run
	always #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			final_report();
		end
	end

	task automatic final_report();
		if (n_fail == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input logic [19:0] got, input logic [19:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// expected beat: lsb first, masks on dq only, dmi plain or floating
	function automatic logic [19:0] cal(input logic [7:0] lo, hi, il, ih,
		input int n, input logic dmi_on);
		logic b;
		b = (n < 8) ? lo[n] : hi[n - 8];
		return {1'b0, !dmi_on, dmi_on ? {2{b}} : 2'b00, {16{b}} ^ {ih, il}};
	endfunction

	task automatic cmd1(input int kind, input logic [5:0] ma,
		input logic [7:0] v);
		model_u.send(kind, v, ma);
		model_u.send(8, 8'h00, 6'h00);
	endtask

	task automatic t_cal_default();
		model_u.rd({2'b01, dqtf_pkg::MPC_RD_CAL}, 1);
		for (int n = 0; n < 16; n++)
			chk(model_u.q[n],
				cal(8'h5A, 8'h3C, 8'h55, 8'h55, n, 1'b1));
	endtask

	// new pattern, both inversion modes on, two chained bursts
	task automatic t_cal_prog();
		cmd1(5, dqtf_pkg::MA_PAT_LO, 8'h1C);
		cmd1(5, dqtf_pkg::MA_PAT_HI, 8'h59);
		cmd1(5, dqtf_pkg::MA_INV_LO, 8'h0F);
		cmd1(5, dqtf_pkg::MA_INV_HI, 8'hF0);
		cmd1(5, dqtf_pkg::MA_DBI, 8'hC0);
		model_u.rd({2'b01, dqtf_pkg::MPC_RD_CAL}, 2);
		for (int n = 0; n < 32; n++)
			chk(model_u.q[n],
				cal(8'h1C, 8'h59, 8'h0F, 8'hF0, n % 16, 1'b1));
	endtask

	// operand bit 6 low, then a reserved code: no burst at all
	task automatic t_ignored();
		logic [7:0] ops [2] = '{8'h03, 8'h45};
		for (int i = 0; i < 2; i++) begin
			model_u.rd(ops[i], 1);
			for (int n = 0; n < 16; n++)
				chk(20'(model_u.q[n][19]), 20'h00001);
		end
	endtask

	// a stray command between mpc and cas-2 drops the pending burst
	task automatic t_stray();
		for (int i = 3; i < 5; i++) begin
			model_u.send(0, {2'b01, dqtf_pkg::MPC_RD_CAL}, 6'h00);
			model_u.send(i, 8'h00, 6'h00);
			cmd1(1, 6'h00, 8'h00);
			repeat (20) begin
				@(negedge ck);
				chk(20'(dq_oe_n), 20'h00001);
			end
		end
	endtask

	// mask off: dmi floats only while both inversion modes are off
	task automatic t_dmi();
		logic [7:0] dbi [3] = '{8'h00, 8'h40, 8'h80};
		cmd1(5, dqtf_pkg::MA_DM, 8'h20);
		for (int i = 0; i < 3; i++) begin
			cmd1(5, dqtf_pkg::MA_DBI, dbi[i]);
			model_u.rd({2'b01, dqtf_pkg::MPC_RD_CAL}, 1);
			for (int n = 0; n < 16; n++)
				chk(model_u.q[n],
					cal(8'h1C, 8'h59, 8'h0F, 8'hF0, n, i != 0));
		end
		cmd1(5, dqtf_pkg::MA_DM, 8'h00);
	endtask

	// k below zero marks an unwritten entry: driven, defined levels
	task automatic rdf(input int k);
		model_u.rd({2'b01, dqtf_pkg::MPC_RD_FIFO}, 1);
		for (int n = 0; n < 16; n++) begin
			if (k < 0)
				chk(20'({model_u.q[n][19], $isunknown(model_u.q[n])}),
					20'h0);
			else
				chk(model_u.q[n],
					{2'b00, model_u.wval(k, n)});
		end
	endtask

	task automatic pchk(input int w, input int r);
		chk({14'h0000, wp, rp}, {14'h0000, 3'(w), 3'(r)});
	endtask

	task automatic t_fifo();
		cmd1(6, 6'h00, 8'h00);
		pchk(0, 0);
		for (int k = 0; k < 3; k++)
			model_u.wr(k);
		pchk(3, 0);
		for (int k = 0; k < 6; k++)
			rdf(k < 3 ? k : (k == 5 ? 0 : -1));
		pchk(3, 1);
		for (int k = 3; k < 6; k++)
			model_u.wr(k);
		pchk(1, 1);
		for (int k = 1; k < 6; k++)
			rdf(k);
		cmd1(2, 6'h00, 8'h00);
		pchk(2, 2);
		cmd1(7, 6'h00, 8'h00);
		pchk(0, 0);
	endtask

	initial begin
		repeat (6) @(negedge sys_clk);
		rst = 1'b0;
		t_cal_default();
		t_cal_prog();
		t_ignored();
		t_stray();
		t_dmi();
		t_fifo();
		final_report();
	end
endmodule // dqtf_core_bench
`default_nettype wire
